// File: core/fast_tenbit_timer_core.sv
// Function
// R1 - One shared 2-bit staging register holds upper bits of 10-bit registers.
// R2 - Reading a low byte copies that register's top bits into staging.
// R3 - Writing a low byte takes the top bits from staging.
// R4 - Upper bits written zero make the timer a plain 8-bit counter.
// R5 - Compare C supplies TOP where the counter clears on match.
// R6 - Compares A, B, D drive pin actions and raise match interrupts.
// R7 - Five request flags: overflow, matches A, B, D, and fault.
// R8 - Each of the five sources is individually maskable.
// R9 - Counter and prescaler may run from the fast peripheral clock.
// R10 - Written values pass synchronisation stages before affecting counting.
// R11 - Control and compare registers read back new values immediately.
// R12 - Count, staging and flags read back with synchronisation delay.
// R13 - System clock must stay below half the fast clock; the core needs the fast clock below half i_clk_sys.
// R14 - BOTTOM is signalled when the count becomes zero.
// R15 - MAX is 0xFF.
// R16 - TOP is fixed MAX or taken from the compare register.
// R17 - Clock select zero stops counting; count stays accessible.
// R18 - Match sets flag next timer clock; cleared by interrupt or one.
// R19 - Count write suppresses matches in the following timer clock.
// R20 - Prescaler reset bit resets the prescaler.
// R21 - Reset zeroes count, compares, staging and all flags.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "ftt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fast_tenbit_timer_core
  import ftt_pkg::*;
#(
  parameter int SYNC_STAGES = `FTT_SYNC_STAGES
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // Avalon-MM slave
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // Timer pins
  input  wire logic        i_fast_periph_clk,
  input  wire logic        i_fault,
  output logic             o_wave_out_a,
  output logic             o_wave_out_b,
  output logic             o_wave_out_d,
  output logic             o_bottom,
  output logic             o_top,
  // Interrupt requests and acknowledges
  output logic      [4:0]  o_irq_req,
  input  wire logic [4:0]  i_irq_ack
);

  initial
  begin
    if (SYNC_STAGES < 1 || SYNC_STAGES > 8)
    begin
      $error("fast_tenbit_timer_core: SYNC_STAGES out of range");
    end
  end

  bus_state_type bus_state;
  logic [7:0]    ctrl_a;
  logic [7:0]    ctrl_b;
  logic [7:0]    ctrl_c;
  logic [5:0]    ctrl_d_low;
  logic          fault_irq_enable;
  logic          fault_flag;
  logic [7:0]    ctrl_e;
  logic [9:0]    compare_a_value;
  logic [9:0]    compare_b_value;
  logic [9:0]    top_compare_value;
  logic [9:0]    compare_d_value;
  logic [3:0]    timer_irq_mask;
  logic [1:0]    msb_staging_reg;
  logic [1:0]    next_staging;
  logic          cnt_load_p;
  logic [9:0]    cnt_val_p;
  logic [3:0]    flag_clr_p;
  logic          psr_p;
  cfg_type       cfg_in;
  cfg_type       cfg_s;
  logic [9:0]    count_value;
  logic [9:0]    next_count;
  logic [3:0]    timer_irq_flags;
  logic [3:0]    flag_set;
  logic [3:0]    flag_clr;
  logic [9:0]    obs_count;
  logic [3:0]    obs_flags;
  logic [1:0]    obs_staging;
  logic          block_q;
  logic          fpc_q;
  logic          half_q;
  logic          fast_tick;
  logic          src_tick;
  logic          tick;
  logic [9:0]    top_val;
  logic          at_top;
  logic [2:0]    hit;

  // Bus decode
  wire        req      = i_read || i_write;
  wire        accept   = req && (bus_state == BUS_ANSWER);
  wire        wr       = accept && i_write && i_byteenable[0];
  // Read taken in its wait cycle, so data and staging copy agree
  wire        rd       = i_read && (bus_state == BUS_IDLE);
  wire [7:0]  wd       = i_writedata[7:0];
  wire        wr_ca    = wr && (i_address == `FTT_OFS_CTRL_A);
  wire        wr_cb    = wr && (i_address == `FTT_OFS_CTRL_B);
  wire        wr_cc    = wr && (i_address == `FTT_OFS_CTRL_C);
  wire        wr_cd    = wr && (i_address == `FTT_OFS_CTRL_D);
  wire        wr_ce    = wr && (i_address == `FTT_OFS_CTRL_E);
  wire        wr_cnt   = wr && (i_address == `FTT_OFS_COUNT);
  wire        wr_stg   = wr && (i_address == `FTT_OFS_STAGING);
  wire        wr_cmpa  = wr && (i_address == `FTT_OFS_CMP_A);
  wire        wr_cmpb  = wr && (i_address == `FTT_OFS_CMP_B);
  wire        wr_cmpt  = wr && (i_address == `FTT_OFS_CMP_TOP);
  wire        wr_cmpd  = wr && (i_address == `FTT_OFS_CMP_D);
  wire        wr_flags = wr && (i_address == `FTT_OFS_FLAGS);
  wire        wr_mask  = wr && (i_address == `FTT_OFS_MASK);
  wire [9:0]  wide_wr  = {msb_staging_reg, wd};

  // Ten-bit register selected by an address
  function automatic logic is_wide(input logic [7:0] a);
    return (a == `FTT_OFS_COUNT) || (a == `FTT_OFS_CMP_A)
        || (a == `FTT_OFS_CMP_B) || (a == `FTT_OFS_CMP_TOP)
        || (a == `FTT_OFS_CMP_D);
  endfunction : is_wide

  function automatic logic [9:0] wide_of(input logic [7:0] a);
    unique case (a)
      `FTT_OFS_COUNT:   return obs_count;
      `FTT_OFS_CMP_A:   return compare_a_value;
      `FTT_OFS_CMP_B:   return compare_b_value;
      `FTT_OFS_CMP_TOP: return top_compare_value;
      `FTT_OFS_CMP_D:   return compare_d_value;
      default:          return 10'h000;
    endcase
  endfunction : wide_of

  function automatic logic [7:0] byte_of(input logic [7:0] a);
    if (is_wide(a))
      return 8'(wide_of(a));
    unique case (a)
      `FTT_OFS_CTRL_A:  return ctrl_a;
      `FTT_OFS_CTRL_B:  return ctrl_b;
      `FTT_OFS_CTRL_C:  return ctrl_c;
      `FTT_OFS_CTRL_D:  return {fault_irq_enable, fault_flag, ctrl_d_low};
      `FTT_OFS_CTRL_E:  return ctrl_e;
      `FTT_OFS_STAGING: return {6'h00, obs_staging};
      `FTT_OFS_FLAGS:   return {4'h0, obs_flags};
      `FTT_OFS_MASK:    return {4'h0, timer_irq_mask};
      default:          return `FTT_RESET_BYTE;
    endcase
  endfunction : byte_of

  wire [9:0]  wide_rd  = wide_of(i_address);

  // One wait cycle, answer in the second
  assign o_waitrequest = req && (bus_state == BUS_IDLE);

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      bus_state <= BUS_IDLE;
    else
      bus_state <= (req && bus_state == BUS_IDLE) ? BUS_ANSWER : BUS_IDLE;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_readdata <= 32'h0000_0000;
    else if (rd)
      o_readdata <= {24'h00_0000, byte_of(i_address)};
  end

  // Shared staging register
  assign next_staging = wr_stg ? wd[1:0]                                  // R1
                      : (rd && is_wide(i_address)) ? wide_rd[9:8] // R2
                      : msb_staging_reg;

  // Registers read back at once after a write, except staging, read back through obs_staging
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_a            <= `FTT_RESET_BYTE;
      ctrl_b            <= `FTT_RESET_BYTE;
      ctrl_c            <= `FTT_RESET_BYTE;
      ctrl_d_low        <= 6'h00;
      fault_irq_enable  <= 1'b0;
      ctrl_e            <= `FTT_RESET_BYTE;
      compare_a_value   <= 10'h000; // R21
      compare_b_value   <= 10'h000;
      top_compare_value <= 10'h000;
      compare_d_value   <= 10'h000;
      timer_irq_mask    <= 4'h0;
      msb_staging_reg   <= 2'h0;
    end
    else
    begin
      msb_staging_reg <= next_staging;
      if (wr_ca)
        ctrl_a <= wd; // R11
      if (wr_cb)
        ctrl_b <= wd & ~(8'h01 << `FTT_PSR_BIT);
      if (wr_cc)
        ctrl_c <= wd;
      if (wr_cd)
      begin
        ctrl_d_low       <= wd[5:0];
        fault_irq_enable <= wd[`FTT_FIE_BIT]; // R8
      end
      if (wr_ce)
        ctrl_e <= wd;
      if (wr_cmpa)
        compare_a_value <= wide_wr; // R3
      if (wr_cmpb)
        compare_b_value <= wide_wr;
      if (wr_cmpt)
        top_compare_value <= wide_wr;
      if (wr_cmpd)
        compare_d_value <= wide_wr;
      if (wr_mask)
        timer_irq_mask <= wd[3:0]; // R8
    end
  end

  // Write strobes that act on the timer side
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_load_p <= 1'b0;
      cnt_val_p  <= 10'h000;
      flag_clr_p <= 4'h0;
      psr_p      <= 1'b0;
    end
    else
    begin
      cnt_load_p <= wr_cnt;
      cnt_val_p  <= wr_cnt ? wide_wr : cnt_val_p; // R3
      flag_clr_p <= wr_flags ? wd[3:0] : 4'h0;
      psr_p      <= wr_cb && wd[`FTT_PSR_BIT]; // R20
    end
  end

  assign cfg_in = '{
    clk_sel:   ctrl_b[3:0],
    top_sel:   ctrl_a[`FTT_TOPSEL_BIT],
    wave_en:   ctrl_a[`FTT_WAVE_EN_LSB +: 3],
    async_sel: ctrl_e[`FTT_ASYNC_BIT],
    low_speed: ctrl_e[`FTT_LSM_BIT],
    cmp_a:     compare_a_value,
    cmp_b:     compare_b_value,
    cmp_top:   top_compare_value,
    cmp_d:     compare_d_value,
    cnt_load:  cnt_load_p,
    cnt_val:   cnt_val_p,
    flag_clr:  flag_clr_p,
    psr:       psr_p
  };

  // Input synchronisation into the counting side
  ftt_sync_bus #(
    .W      ($bits(cfg_type)),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_data    (cfg_in), // R10
    .o_data    (cfg_s)
  );

  // Fast peripheral clock edges, halved in low speed mode
  assign fast_tick = i_fast_periph_clk && !fpc_q
                     && (!cfg_s.low_speed || half_q); // R9
  assign src_tick  = cfg_s.async_sel ? fast_tick : 1'b1;

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      fpc_q  <= 1'b0;
      half_q <= 1'b0;
    end
    else
    begin
      fpc_q  <= i_fast_periph_clk;
      half_q <= half_q ^ (i_fast_periph_clk && !fpc_q);
    end
  end

  ftt_prescaler #(
    .PRE_W (`FTT_PRE_WIDTH)
  ) u_pre (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_src_tick  (src_tick),
    .i_clk_sel   (cfg_s.clk_sel), // R17
    .i_reset_pre (cfg_s.psr), // R20
    .o_tick      (tick)
  );

  // Counter
  assign top_val    = cfg_s.top_sel ? cfg_s.cmp_top : `FTT_MAX_VAL; // R4 R5 R15 R16
  assign at_top     = (count_value == top_val);
  assign next_count = cfg_s.cnt_load ? cfg_s.cnt_val
                    : !tick ? count_value
                    : at_top ? `FTT_BOTTOM_VAL
                    : count_value + 10'h001;
  assign hit        = {count_value == cfg_s.cmp_d,
                       count_value == cfg_s.cmp_b,
                       count_value == cfg_s.cmp_a};
  assign flag_set   = {4{tick}} & {hit[2] && !block_q, hit[1] && !block_q,
                                   hit[0] && !block_q, at_top}; // R6 R18 R19
  assign flag_clr   = cfg_s.flag_clr | i_irq_ack[3:0];

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      count_value     <= 10'h000; // R21
      timer_irq_flags <= 4'h0;
      block_q         <= 1'b0;
      o_bottom        <= 1'b1;
      o_top           <= 1'b0;
    end
    else
    begin
      count_value     <= next_count; // R17
      timer_irq_flags <= (timer_irq_flags & ~flag_clr) | flag_set; // R7 R18
      block_q         <= cfg_s.cnt_load || (block_q && !tick); // R19
      o_bottom        <= (next_count == `FTT_BOTTOM_VAL); // R14
      o_top           <= (next_count == top_val);
    end
  end

  // Pin actions on matches
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_wave_out_a <= 1'b0;
      o_wave_out_b <= 1'b0;
      o_wave_out_d <= 1'b0;
    end
    else
    begin
      o_wave_out_a <= o_wave_out_a ^ (flag_set[`FTT_FLAG_MA] && cfg_s.wave_en[0]); // R6
      o_wave_out_b <= o_wave_out_b ^ (flag_set[`FTT_FLAG_MB] && cfg_s.wave_en[1]);
      o_wave_out_d <= o_wave_out_d ^ (flag_set[`FTT_FLAG_MD] && cfg_s.wave_en[2]);
    end
  end

  // Output synchronisation and fault flag
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      obs_count   <= 10'h000;
      obs_flags   <= 4'h0;
      obs_staging <= 2'h0;
      fault_flag  <= 1'b0;
    end
    else
    begin
      obs_count   <= count_value; // R12
      obs_flags   <= timer_irq_flags;
      obs_staging <= msb_staging_reg;
      fault_flag  <= i_fault || (fault_flag && !i_irq_ack[4]
                     && !(wr_cd && wd[`FTT_FF_BIT])); // R7
    end
  end

  assign o_irq_req = {fault_flag && fault_irq_enable,
                      timer_irq_flags & timer_irq_mask}; // R8

  answer_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R11
    req && o_waitrequest |=> !o_waitrequest)
    else $error("answer not given one cycle after wait");
  staging_copy_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R2
    rd && i_address == `FTT_OFS_COUNT |=> msb_staging_reg == $past(obs_count[9:8]))
    else $error("staging not loaded from count read");
  low_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R3
    wr_cmpa |=> compare_a_value == {$past(msb_staging_reg), $past(wd)})
    else $error("compare A not built from staging");
  sync_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R10
    wr_cmpa && SYNC_STAGES == 2 |=> ##2 cfg_s.cmp_a == $past(compare_a_value, 2))
    else $error("compare A not synchronised in two stages");
  stop_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R17
    cfg_s.clk_sel == 4'h0 && !cfg_s.cnt_load |=> count_value == $past(count_value))
    else $error("count moved while stopped");
  top_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R5
    tick && at_top && !cfg_s.cnt_load
    |=> count_value == 10'h000 && timer_irq_flags[`FTT_FLAG_OVF])
    else $error("no clear and overflow at TOP");
  match_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R18
    tick && hit[0] && !block_q |=> timer_irq_flags[`FTT_FLAG_MA])
    else $error("match A flag not set");
  match_block_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R19
    cfg_s.cnt_load ##1 (tick && !timer_irq_flags[`FTT_FLAG_MA])
    |=> !timer_irq_flags[`FTT_FLAG_MA])
    else $error("match not blocked after count write");
  fault_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R7
    i_fault |=> fault_flag ##0 (o_irq_req[4] == fault_irq_enable))
    else $error("fault flag lost");

  overflow_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    flag_set[`FTT_FLAG_OVF]);
  count_write_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    cfg_s.cnt_load ##[1:20] tick);
  fault_irq_c: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_irq_req[4]);

endmodule : fast_tenbit_timer_core
`default_nettype wire

// File: core/ftt_params.svh
`ifndef FTT_PARAMS_SVH
`define FTT_PARAMS_SVH

// Register byte offsets
`define FTT_OFS_CTRL_A    8'h00
`define FTT_OFS_CTRL_B    8'h04
`define FTT_OFS_CTRL_C    8'h08
`define FTT_OFS_CTRL_D    8'h0C
`define FTT_OFS_CTRL_E    8'h10
`define FTT_OFS_COUNT     8'h14
`define FTT_OFS_STAGING   8'h18
`define FTT_OFS_CMP_A     8'h1C
`define FTT_OFS_CMP_B     8'h20
`define FTT_OFS_CMP_TOP   8'h24
`define FTT_OFS_CMP_D     8'h28
`define FTT_OFS_FLAGS     8'h2C
`define FTT_OFS_MASK      8'h30

// Field positions
`define FTT_TOPSEL_BIT    0
`define FTT_WAVE_EN_LSB   1
`define FTT_PSR_BIT       6
`define FTT_FIE_BIT       7
`define FTT_FF_BIT        6
`define FTT_ASYNC_BIT     0
`define FTT_LSM_BIT       1
`define FTT_FLAG_OVF      0
`define FTT_FLAG_MA       1
`define FTT_FLAG_MB       2
`define FTT_FLAG_MD       3

// Values
`define FTT_RESET_BYTE    8'h00
`define FTT_MAX_VAL       10'h0FF
`define FTT_BOTTOM_VAL    10'h000
`define FTT_SYNC_STAGES   2
`define FTT_PRE_WIDTH     14

`endif

// File: core/ftt_pkg.sv
package ftt_pkg;

  typedef enum logic
  {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_type;

  // Settings carried into the timer side
  typedef struct packed
  {
    logic [3:0] clk_sel;
    logic       top_sel;
    logic [2:0] wave_en;
    logic       async_sel;
    logic       low_speed;
    logic [9:0] cmp_a;
    logic [9:0] cmp_b;
    logic [9:0] cmp_top;
    logic [9:0] cmp_d;
    logic       cnt_load;
    logic [9:0] cnt_val;
    logic [3:0] flag_clr;
    logic       psr;
  } cfg_type;

endpackage : ftt_pkg

// File: core/ftt_sync_bus.sv
`timescale 1ns/1ps
`default_nettype none
module ftt_sync_bus #(
  parameter int W      = 8,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  // Data
  input  wire logic [W-1:0] i_data,
  output logic      [W-1:0] o_data
);

  logic [W-1:0] stage [STAGES];

  initial
  begin
    if (STAGES < 1 || W < 1)
    begin
      $error("ftt_sync_bus: STAGES and W must be at least 1");
    end
  end

  genvar g;
  generate
    for (g = 0; g < STAGES; g++)
    begin : g_stage
      always_ff @(posedge i_clk_sys or negedge i_reset_n)
      begin
        if (!i_reset_n)
          stage[g] <= '0;
        else
          stage[g] <= (g == 0) ? i_data : stage[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate

  assign o_data = stage[STAGES-1];

endmodule : ftt_sync_bus
`default_nettype wire

// File: core/ftt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module ftt_prescaler #(
  parameter int PRE_W = 14
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  // Control
  input  wire logic       i_src_tick,
  input  wire logic [3:0] i_clk_sel,
  input  wire logic       i_reset_pre,
  // Timer tick
  output logic            o_tick
);

  logic [PRE_W-1:0] pre_cnt;
  logic [PRE_W-1:0] div_mask;

  initial
  begin
    if (PRE_W < 14)
    begin
      $error("ftt_prescaler: PRE_W must be at least 14");
    end
  end

  // Low sel-1 bits set: divide by 2^(sel-1)
  function automatic logic [PRE_W-1:0] mask_of(input logic [3:0] sel);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++)
      m[i] = (i + 1 < int'(sel));
    return m;
  endfunction : mask_of

  assign div_mask = mask_of(i_clk_sel);
  assign o_tick   = i_src_tick && (i_clk_sel != 4'h0)
                    && ((pre_cnt & div_mask) == div_mask);

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pre_cnt <= '0;
    else if (i_reset_pre)
      pre_cnt <= '0;
    else if (i_src_tick)
      pre_cnt <= pre_cnt + 1'b1;
  end

endmodule : ftt_prescaler
`default_nettype wire

// File: verif/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Avalon-MM master
  output logic      [7:0]  o_address,
  output logic             o_read,
  output logic             o_write,
  output logic      [31:0] o_writedata,
  output logic      [3:0]  o_byteenable,
  input  wire logic [31:0] i_readdata,
  input  wire logic        i_waitrequest
);
  int timeouts;

  initial
  begin
    o_address    = 8'h00;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_writedata  = 32'h0000_0000;
    o_byteenable = 4'h0;
    timeouts     = 0;
  end

  // Request held until accepted, so the sync stages never lose it
  task automatic access(input logic [7:0] addr, input logic rd, input logic [7:0] data,
                        input logic [3:0] be, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    o_address    <= addr;
    o_read       <= rd;
    o_write      <= !rd;
    o_writedata  <= {24'h00_0000, data};
    o_byteenable <= be;
    @(posedge i_clk_sys);
    while (i_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n >= 50)
      timeouts++;
    rdata = i_readdata;
    o_read  <= 1'b0;
    o_write <= 1'b0;
  endtask : access
endmodule : cpu_bus_model
`default_nettype wire

// File: verif/testbench.sv
`include "ftt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ftt_pkg::*;
  logic        clk_sys;
  logic        reset_n;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        fast_clk;
  logic [1:0]  fast_ph;
  logic        fault;
  logic        wave_a;
  logic        wave_b;
  logic        wave_d;
  logic        bottom;
  logic        top;
  logic [4:0]  irq_req;
  logic [4:0]  irq_ack;
  logic        wave_a_q;
  logic        wave_b_q;
  int          toggles_a;
  int          toggles_b;
  int          num_errors;
  int          total_checks;
  int          model [int];
  logic [7:0]  seed;
  logic [7:0]  d;
  logic [7:0]  d2;
  logic [31:0] rsink;
  logic [7:0]  rb_addr [5];
  int          src_div [6];
  int          sel_tab [6];
  logic [7:0]  e_tab [6];

  fast_tenbit_timer_core u_fast_tenbit_timer_core (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_address(address), .i_read(read),
    .i_write(write), .i_writedata(writedata), .i_byteenable(byteenable),
    .o_readdata(readdata), .o_waitrequest(waitrequest), .i_fast_periph_clk(fast_clk),
    .i_fault(fault), .o_wave_out_a(wave_a), .o_wave_out_b(wave_b), .o_wave_out_d(wave_d),
    .o_bottom(bottom), .o_top(top), .o_irq_req(irq_req), .i_irq_ack(irq_ack));

  cpu_bus_model u_cpu_bus_model (
    .i_clk_sys(clk_sys), .o_address(address), .o_read(read), .o_write(write),
    .o_writedata(writedata), .o_byteenable(byteenable), .i_readdata(readdata),
    .i_waitrequest(waitrequest));

  initial
  begin
    clk_sys = 1'b0;
    forever
      #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    fast_ph  <= fast_ph + 2'h1;
    fast_clk <= fast_ph[1];
    wave_a_q <= wave_a;
    wave_b_q <= wave_b;
    if (wave_a_q !== wave_a)
      toggles_a <= toggles_a + 1;
    if (wave_b_q !== wave_b)
      toggles_b <= toggles_b + 1;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      num_errors++;
    end
  endtask : check

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [31:0] r;
    u_cpu_bus_model.access(addr, 1'b0, data, 4'h1, r);
    model[addr] = data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    logic [31:0] r;
    u_cpu_bus_model.access(addr, 1'b1, 8'h00, 4'h1, r);
    check({24'h00_0000, 8'h00}, r & 32'hFFFF_FF00, "upper readdata");
    data = r[7:0];
  endtask : rd

  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    rd(addr, v);
    check(v, exp, "register read");
  endtask : rdchk

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic measure(input logic [7:0] ctl_e, input logic [3:0] sel, input int exp_cnt);
    logic [7:0] v;
    int diff;
    wr(`FTT_OFS_CTRL_B, 8'h00);
    wr(`FTT_OFS_CTRL_E, ctl_e);
    wr(`FTT_OFS_STAGING, 8'h00);
    wr(`FTT_OFS_COUNT, 8'h00);
    repeat (8) @(posedge clk_sys);
    check(bottom, 1'b1, "bottom at zero");
    wr(`FTT_OFS_CTRL_B, 8'h40 | {4'h0, sel});
    repeat (128) @(posedge clk_sys);
    wr(`FTT_OFS_CTRL_B, 8'h00);
    repeat (8) @(posedge clk_sys);
    rd(`FTT_OFS_COUNT, v);
    diff = int'(v) - exp_cnt;
    check(diff <= 6 && diff >= -6, 1'b1, "count rate");
  endtask : measure

  task automatic finish_test;
    num_errors += u_cpu_bus_model.timeouts;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  initial
  begin
    reset_n = 1'b0;
    fault = 1'b0;
    irq_ack = 5'h00;
    fast_ph = 2'h0;
    fast_clk = 1'b0;
    toggles_a = 0;
    toggles_b = 0;
    num_errors = 0;
    total_checks = 0;
    seed = 8'h16;
    rb_addr = '{`FTT_OFS_CTRL_C, `FTT_OFS_CMP_A, `FTT_OFS_CMP_B, `FTT_OFS_CMP_D, `FTT_OFS_CMP_TOP};
    src_div = '{1, 1, 1, 1, 4, 8};
    sel_tab = '{1, 2, 3, 4, 1, 1};
    e_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03};
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    check(bottom, 1'b1, "bottom after reset");
    check(irq_req, 5'h00, "irq after reset");
    foreach (rb_addr[i]) rdchk(rb_addr[i] == `FTT_OFS_CTRL_C ? `FTT_OFS_COUNT : rb_addr[i], 8'h00);
    rdchk(`FTT_OFS_STAGING, 8'h00);
    rdchk(`FTT_OFS_FLAGS, 8'h00);
    end_test("reset");

    wr(`FTT_OFS_STAGING, 8'h00);
    foreach (rb_addr[i])
    begin
      seed = lfsr_next(seed);
      wr(rb_addr[i], seed);
      rdchk(rb_addr[i], model[rb_addr[i]]);
    end
    u_cpu_bus_model.access(`FTT_OFS_CMP_B, 1'b0, ~seed, 4'h0, rsink);
    rdchk(`FTT_OFS_CMP_B, model[`FTT_OFS_CMP_B]);
    rdchk(8'h3C, 8'h00);
    end_test("readback");

    wr(`FTT_OFS_STAGING, 8'h02);
    wr(`FTT_OFS_CMP_D, 8'h5A);
    wr(`FTT_OFS_STAGING, 8'h00);
    rdchk(`FTT_OFS_CMP_D, 8'h5A);
    rdchk(`FTT_OFS_STAGING, 8'h02);
    end_test("staging");

    wr(`FTT_OFS_STAGING, 8'h00);
    wr(`FTT_OFS_CTRL_A, 8'h00);
    wr(`FTT_OFS_COUNT, 8'hF0);
    wr(`FTT_OFS_FLAGS, 8'h0F);
    wr(`FTT_OFS_CTRL_B, 8'h01);
    repeat (20) @(posedge clk_sys);
    wr(`FTT_OFS_COUNT, 8'hF8);
    repeat (20) @(posedge clk_sys);
    wr(`FTT_OFS_CTRL_B, 8'h00);
    repeat (8) @(posedge clk_sys);
    rd(`FTT_OFS_FLAGS, d);
    check(d[0], 1'b1, "overflow at max");
    rd(`FTT_OFS_COUNT, d);
    check(d < 8'h40, 1'b1, "wrapped count");
    rdchk(`FTT_OFS_STAGING, 8'h00);
    end_test("eight_bit");

    wr(`FTT_OFS_MASK, 8'h02);
    wr(`FTT_OFS_CTRL_A, 8'h03);
    wr(`FTT_OFS_CMP_A, 8'h04);
    wr(`FTT_OFS_CMP_B, 8'h3F);
    wr(`FTT_OFS_CMP_D, 8'h07);
    wr(`FTT_OFS_CMP_TOP, 8'h09);
    wr(`FTT_OFS_COUNT, 8'h00);
    wr(`FTT_OFS_FLAGS, 8'h0F);
    repeat (8) @(posedge clk_sys);
    toggles_a = 0;
    toggles_b = 0;
    wr(`FTT_OFS_CTRL_B, 8'h01);
    repeat (60) @(posedge clk_sys);
    wr(`FTT_OFS_CTRL_B, 8'h00);
    repeat (8) @(posedge clk_sys);
    check(toggles_a >= 4, 1'b1, "wave a toggles");
    check(toggles_b, 0, "wave b quiet");
    rdchk(`FTT_OFS_FLAGS, 8'h0B);
    rd(`FTT_OFS_COUNT, d);
    check(d <= 8'h09, 1'b1, "count within top");
    check(top, d == 8'h09, "top level");
    check(wave_d, 1'b0, "wave d disabled");
    repeat (20) @(posedge clk_sys);
    rd(`FTT_OFS_COUNT, d2);
    check(d2, d, "stopped count");
    check(irq_req, 5'h02, "masked irq");
    @(posedge clk_sys);
    irq_ack <= 5'h02;
    @(posedge clk_sys);
    irq_ack <= 5'h00;
    repeat (4) @(posedge clk_sys);
    check(irq_req, 5'h00, "irq after ack");
    rdchk(`FTT_OFS_FLAGS, 8'h09);
    wr(`FTT_OFS_FLAGS, 8'h01);
    repeat (8) @(posedge clk_sys);
    rdchk(`FTT_OFS_FLAGS, 8'h08);
    end_test("compare");

    @(posedge clk_sys);
    fault <= 1'b1;
    @(posedge clk_sys);
    fault <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rdchk(`FTT_OFS_CTRL_D, 8'h40);
    check(irq_req[4], 1'b0, "fault masked");
    wr(`FTT_OFS_CTRL_D, 8'h80);
    repeat (2) @(posedge clk_sys);
    check(irq_req[4], 1'b1, "fault irq");
    wr(`FTT_OFS_CTRL_D, 8'hC0);
    rdchk(`FTT_OFS_CTRL_D, 8'h80);
    end_test("fault");

    wr(`FTT_OFS_CTRL_A, 8'h00);
    for (int i = 0; i < 6; i++) measure(e_tab[i], sel_tab[i][3:0], (131 / src_div[i]) >> (sel_tab[i] - 1));
    end_test("rates");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
